/* rtl/ams_mute_select.sv */
// Mute source select registers with APB slave and pin routing
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "ams_defines.svh"

module ams_mute_select #(
	parameter bit HAS_PORT2    = 1'b1,
	parameter bit FIX_MISPRINT = 1'b0
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Candidate source pins
	input  wire logic        audio0SerialData7,
	input  wire logic        audio0SerialData8,
	input  wire logic        audio0SerialData9,
	input  wire logic        audio2HfReceiveClock,
	input  wire logic        serif0SlaveInPin,
	input  wire logic        serif0ChipSelectPin,
	input  wire logic        serif0EnablePin,
	input  wire logic        serif0MisprintedPin,
	// Mute inputs of the audio ports
	output logic             port0MuteSource,
	output logic             port1MuteSource,
	output logic             port2MuteSource
);

	import ams_pkg::*;

	// ********************************
	// Declarations
	// ********************************
	localparam int NP = `AMS_NUM_PORTS;

	ams_src_t                  selReg [NP];
	logic [`AMS_PIN_COUNT-1:0] rawPins;
	logic [`AMS_PIN_COUNT-1:0] syncPins;
	logic [NP-1:0]             muteOut;
	logic [NP-1:0]             hit;
	logic                      mapped;
	logic                      accessPhase;
	logic                      commit;
	logic [31:0]               next_prdata;

	// ********************************
	// Pin synchronisation
	// ********************************
	assign rawPins[`AMS_PIN_DATA7]    = audio0SerialData7;
	assign rawPins[`AMS_PIN_DATA8]    = audio0SerialData8;
	assign rawPins[`AMS_PIN_DATA9]    = audio0SerialData9;
	assign rawPins[`AMS_PIN_HFCLK]    = audio2HfReceiveClock;
	assign rawPins[`AMS_PIN_SLVIN]    = serif0SlaveInPin;
	assign rawPins[`AMS_PIN_CHIPSEL]  = serif0ChipSelectPin;
	assign rawPins[`AMS_PIN_ENABLE]   = serif0EnablePin;
	assign rawPins[`AMS_PIN_MISPRINT] = serif0MisprintedPin;

	// Pins are asynchronous, possibly clocks; mute sees them late by three
	ams_sync2 #(
		.WIDTH (`AMS_PIN_COUNT)
	) uSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (rawPins),
		.syncOut (syncPins)
	);

	// ********************************
	// APB decode
	// ********************************
	// Absent third register decodes as unmapped
	assign hit[0] = (paddr == `AMS_ADDR_PORT0);
	assign hit[1] = (paddr == `AMS_ADDR_PORT1);
	assign hit[2] = (paddr == `AMS_ADDR_PORT2) && HAS_PORT2;
	assign mapped = |hit;

	assign accessPhase = psel && penable;
	// One wait state: pready rises on the second access cycle
	assign commit      = accessPhase && pready;

	always_comb
	begin
		next_prdata = 32'h0000_0000;
		for (int k = 0; k < NP; k++)
		begin
			if (hit[k])
				next_prdata[`AMS_SEL_MSB:`AMS_SEL_LSB] = selReg[k];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pready <= 1'b0;
		else
			pready <= accessPhase && !pready;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (accessPhase && !pready && !pwrite)
			prdata <= next_prdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pslverr <= 1'b0;
		else if (accessPhase && !pready)
			pslverr <= !mapped;
		else
			pslverr <= 1'b0;
	end

	// ********************************
	// Selector registers and routing
	// ********************************
	generate
		for (genvar i = 0; i < NP; i++)
		begin : gPort
			// Reserved write bits are dropped; only the field is kept
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					selReg[i] <= `AMS_SEL_RESET;
				else if (commit && pwrite && hit[i])
					selReg[i] <=
						pwdata[`AMS_SEL_MSB:`AMS_SEL_LSB];
			end

			ams_src_mux #(
				.IS_THIRD     (i == 2),
				.FIX_MISPRINT (FIX_MISPRINT),
				.PRESENT      (i != 2 || HAS_PORT2)
			) uMux (
				.clk   (clk),
				.rst_n (rst_n),
				.sel   (selReg[i]),
				.pins  (syncPins),
				.mute  (muteOut[i])
			);
		end
	endgenerate

	assign port0MuteSource = muteOut[0];
	assign port1MuteSource = muteOut[1];
	assign port2MuteSource = muteOut[2];

	// ********************************
	// Assertions
	// ********************************
	logic chipSelSrc;
	logic enableSrc;

	// Sources the lower ports use for codes 110 and 111
	assign chipSelSrc = FIX_MISPRINT ? syncPins[`AMS_PIN_CHIPSEL]
	                                 : syncPins[`AMS_PIN_SLVIN];
	assign enableSrc  = FIX_MISPRINT ? syncPins[`AMS_PIN_ENABLE]
	                                 : syncPins[`AMS_PIN_MISPRINT];

	AST_WRITE_FIELD: assert property (
		@(posedge clk) disable iff (!rst_n)
		(commit && pwrite && hit[0])
		|=> (selReg[0] == $past(pwdata[2:0])) && !pready
	) else $error("selector write not stored");

	AST_CODE_ZERO: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[0] == `AMS_CODE_ZERO) && (selReg[1] == `AMS_CODE_ZERO)
		|=> !port0MuteSource && !port1MuteSource
	) else $error("code zero did not give constant zero");

	AST_CODE_DATA7: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[1] == `AMS_CODE_DATA7)
		|=> port1MuteSource == $past(syncPins[`AMS_PIN_DATA7])
	) else $error("code 001 routed wrong pin");

	AST_CODE_DATA89: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[0] == `AMS_CODE_DATA8) ##1 (selReg[0] == `AMS_CODE_DATA9)
		|-> (port0MuteSource == $past(syncPins[`AMS_PIN_DATA8]))
		##1 (port0MuteSource == $past(syncPins[`AMS_PIN_DATA9]))
	) else $error("codes 010/011 routed wrong pins");

	AST_CODE_HFCLK: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[0] == `AMS_CODE_HFCLK)
		|=> port0MuteSource == $past(syncPins[`AMS_PIN_HFCLK])
	) else $error("code 100 routed wrong pin");

	AST_CODE_SLVIN: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[1] == `AMS_CODE_SLVIN)
		|=> port1MuteSource == $past(syncPins[`AMS_PIN_SLVIN])
	) else $error("code 101 routed wrong pin");

	AST_THIRD_CHIPSEL: assert property (
		@(posedge clk) disable iff (!rst_n)
		HAS_PORT2 && (selReg[2] == `AMS_CODE_CHIPSEL)
		|=> port2MuteSource == $past(syncPins[`AMS_PIN_CHIPSEL])
	) else $error("third port code 110 routed wrong pin");

	AST_THIRD_ENABLE: assert property (
		@(posedge clk) disable iff (!rst_n)
		HAS_PORT2 && (selReg[2] == `AMS_CODE_ENABLE)
		|=> port2MuteSource == $past(syncPins[`AMS_PIN_ENABLE])
	) else $error("third port code 111 routed wrong pin");

	AST_LOW_CODE6: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[0] == `AMS_CODE_CHIPSEL)
		|=> port0MuteSource == $past(chipSelSrc)
	) else $error("lower port code 110 routed wrong pin");

	AST_LOW_CODE7: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[1] == `AMS_CODE_ENABLE)
		|=> port1MuteSource == $past(enableSrc)
	) else $error("lower port code 111 routed wrong pin");

	AST_RESERVED_ZERO: assert property (
		@(posedge clk) disable iff (!rst_n)
		(accessPhase && !pready && !pwrite)
		|=> pready && (prdata[31:3] == 29'h0)
	) else $error("reserved bits read nonzero");

	AST_NO_THIRD: assert property (
		@(posedge clk) disable iff (!rst_n)
		!HAS_PORT2 |-> !port2MuteSource
		&& !(commit && hit[2])
	) else $error("absent third selector active");

	AST_RESET_ZERO: assert property (
		@(posedge clk)
		!rst_n |=> (selReg[0] == `AMS_SEL_RESET)
		&& (selReg[1] == `AMS_SEL_RESET) && (selReg[2] == `AMS_SEL_RESET)
		&& !port0MuteSource && !port1MuteSource && !port2MuteSource
	) else $error("reset did not clear selectors");

	AST_CODE_ZERO_P2: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[2] == `AMS_CODE_ZERO) |=> !port2MuteSource
	) else $error("third port code zero not constant zero");

	AST_P2_DATA7: assert property (
		@(posedge clk) disable iff (!rst_n)
		HAS_PORT2 && (selReg[2] == `AMS_CODE_DATA7)
		|=> port2MuteSource == $past(syncPins[`AMS_PIN_DATA7])
	) else $error("third port code 001 routed wrong pin");

	AST_P1_HFCLK: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[1] == `AMS_CODE_HFCLK)
		|=> port1MuteSource == $past(syncPins[`AMS_PIN_HFCLK])
	) else $error("port 1 code 100 routed wrong pin");

	AST_P2_SLVIN: assert property (
		@(posedge clk) disable iff (!rst_n)
		HAS_PORT2 && (selReg[2] == `AMS_CODE_SLVIN)
		|=> port2MuteSource == $past(syncPins[`AMS_PIN_SLVIN])
	) else $error("third port code 101 routed wrong pin");

	AST_LOW_CODE6_P1: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[1] == `AMS_CODE_CHIPSEL)
		|=> port1MuteSource == $past(chipSelSrc)
	) else $error("port 1 code 110 routed wrong pin");

	AST_LOW_CODE7_P0: assert property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[0] == `AMS_CODE_ENABLE)
		|=> port0MuteSource == $past(enableSrc)
	) else $error("port 0 code 111 routed wrong pin");

	AST_READ_DATA: assert property (
		@(posedge clk) disable iff (!rst_n)
		(accessPhase && !pready && !pwrite && hit[1])
		|=> prdata[2:0] == $past(selReg[1])
	) else $error("selector read back wrong");

	AST_UNMAPPED_KEEPS: assert property (
		@(posedge clk) disable iff (!rst_n)
		(commit && pwrite && !mapped)
		|=> $stable(selReg[0]) && $stable(selReg[1]) && $stable(selReg[2])
	) else $error("unmapped write changed a selector");

	AST_PREADY_ONE_WAIT: assert property (
		@(posedge clk) disable iff (!rst_n)
		(accessPhase && !pready) |=> pready ##1 !pready
	) else $error("access did not take exactly one wait state");

	AST_ERR_WITH_READY: assert property (
		@(posedge clk) disable iff (!rst_n)
		pslverr |-> pready
	) else $error("error response without ready");

	// Smallest variant must refuse the third register, not drop it quietly
	AST_NO_THIRD_ERR: assert property (
		@(posedge clk) disable iff (!rst_n)
		!HAS_PORT2 && accessPhase && !pready
		&& (paddr == `AMS_ADDR_PORT2) |=> pslverr
	) else $error("absent third selector gave no error");

	COV_WRITE_THEN_ROUTE: cover property (
		@(posedge clk) disable iff (!rst_n)
		(commit && pwrite && hit[2]) ##1 (selReg[2] != `AMS_CODE_ZERO)
		##1 port2MuteSource
	);

	COV_READ_BACK: cover property (
		@(posedge clk) disable iff (!rst_n)
		commit && !pwrite && mapped && (prdata[2:0] != 3'h0)
	);

	COV_UNMAPPED: cover property (
		@(posedge clk) disable iff (!rst_n)
		commit && pslverr
	);

	COV_MISPRINT_ROUTE: cover property (
		@(posedge clk) disable iff (!rst_n)
		(selReg[1] == `AMS_CODE_ENABLE) ##1 port1MuteSource
	);

	COV_RESET_AFTER_WRITE: cover property (
		@(posedge clk)
		(selReg[0] != `AMS_CODE_ZERO) ##1 !rst_n
	);

endmodule

/* rtl/ams_defines.svh */
// Register map, field layout, source codes and pin indices for mute select
`ifndef AMS_DEFINES_SVH
`define AMS_DEFINES_SVH

// ********************************
// Register map
// ********************************
`define AMS_ADDR_PORT0      32'h4000_0018
`define AMS_ADDR_PORT1      32'h4000_001C
`define AMS_ADDR_PORT2      32'h4000_0020
`define AMS_SEL_MSB         2
`define AMS_SEL_LSB         0
`define AMS_SEL_RESET       3'h0
`define AMS_NUM_PORTS       3

// ********************************
// Selector codes
// ********************************
`define AMS_CODE_ZERO       3'h0
`define AMS_CODE_DATA7      3'h1
`define AMS_CODE_DATA8      3'h2
`define AMS_CODE_DATA9      3'h3
`define AMS_CODE_HFCLK      3'h4
`define AMS_CODE_SLVIN      3'h5
`define AMS_CODE_CHIPSEL    3'h6
`define AMS_CODE_ENABLE     3'h7

// ********************************
// Synchronised pin vector indices
// ********************************
`define AMS_PIN_COUNT       8
`define AMS_PIN_DATA7       0
`define AMS_PIN_DATA8       1
`define AMS_PIN_DATA9       2
`define AMS_PIN_HFCLK       3
`define AMS_PIN_SLVIN       4
`define AMS_PIN_CHIPSEL     5
`define AMS_PIN_ENABLE      6
`define AMS_PIN_MISPRINT    7

`endif

/* rtl/ams_pkg.sv */
// Types shared by the mute source select block
package ams_pkg;

	typedef logic [2:0] ams_src_t;

endpackage

/* rtl/ams_sync2.sv */
// Two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps

module ams_sync2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stage1  <= '0;
			syncOut <= '0;
		end
		else
		begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end

endmodule

/* rtl/ams_src_mux.sv */
// Per-port mute source multiplexer with a registered output
`timescale 1ns/1ps
`include "ams_defines.svh"

module ams_src_mux #(
	parameter bit IS_THIRD     = 1'b0,
	parameter bit FIX_MISPRINT = 1'b0,
	parameter bit PRESENT      = 1'b1
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Selector and synchronised pins
	input  wire ams_pkg::ams_src_t          sel,
	input  wire logic [`AMS_PIN_COUNT-1:0]  pins,
	// Mute input of the audio port
	output logic                            mute
);

	import ams_pkg::*;

	logic next_mute;

	always_comb
	begin
		next_mute = 1'b0;
		case (sel)
			`AMS_CODE_ZERO:    next_mute = 1'b0;
			`AMS_CODE_DATA7:   next_mute = pins[`AMS_PIN_DATA7];
			`AMS_CODE_DATA8:   next_mute = pins[`AMS_PIN_DATA8];
			`AMS_CODE_DATA9:   next_mute = pins[`AMS_PIN_DATA9];
			`AMS_CODE_HFCLK:   next_mute = pins[`AMS_PIN_HFCLK];
			`AMS_CODE_SLVIN:   next_mute = pins[`AMS_PIN_SLVIN];
			// Ports 0 and 1 keep the printed choice unless corrected
			`AMS_CODE_CHIPSEL: next_mute = (IS_THIRD || FIX_MISPRINT) ?
				pins[`AMS_PIN_CHIPSEL] : pins[`AMS_PIN_SLVIN];
			`AMS_CODE_ENABLE:  next_mute = (IS_THIRD || FIX_MISPRINT) ?
				pins[`AMS_PIN_ENABLE] : pins[`AMS_PIN_MISPRINT];
			default:           next_mute = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mute <= 1'b0;
		else
			mute <= PRESENT ? next_mute : 1'b0;
	end

endmodule

/* test/audio_mute_input_select_tb.sv */
// Self-checking bench for the mute source select block
`timescale 1ns/1ps
`include "ams_defines.svh"

module audio_mute_input_select_tb;
	import ams_pkg::*;

	// ********************************
	// Signals
	// ********************************
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        smallErr;
	logic        smallMute2;
	logic [7:0]  pins;
	logic [2:0]  mute;
	int          n_mismatch;
	int          checked;

	// ********************************
	// Designs: full part and smallest variant
	// ********************************
	ams_mute_select dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.audio0SerialData7(pins[0]), .audio0SerialData8(pins[1]),
		.audio0SerialData9(pins[2]), .audio2HfReceiveClock(pins[3]),
		.serif0SlaveInPin(pins[4]), .serif0ChipSelectPin(pins[5]),
		.serif0EnablePin(pins[6]), .serif0MisprintedPin(pins[7]),
		.port0MuteSource(mute[0]), .port1MuteSource(mute[1]),
		.port2MuteSource(mute[2])
	);

	// Shares the bus; its answers line up with the full part's
	ams_mute_select #(.HAS_PORT2(1'b0)) dutSmall (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(smallErr),
		.audio0SerialData7(pins[0]), .audio0SerialData8(pins[1]),
		.audio0SerialData9(pins[2]), .audio2HfReceiveClock(pins[3]),
		.serif0SlaveInPin(pins[4]), .serif0ChipSelectPin(pins[5]),
		.serif0EnablePin(pins[6]), .serif0MisprintedPin(pins[7]),
		.port0MuteSource(), .port1MuteSource(),
		.port2MuteSource(smallMute2)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ********************************
	// Shared tasks
	// ********************************
	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; waits for pready, never assumes a latency
	task apb(input logic wr, input logic [31:0] addr,
		input logic [31:0] wdata, output logic [31:0] rdata,
		output logic err, output logic errSmall);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		check("pready", {31'h0, pready}, 32'h1);
		rdata    = prdata;
		err      = pslverr;
		errSmall = smallErr;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
	endtask

	// Pin index a code routes to; 8 stands for the constant zero
	function automatic int exp_idx(input int p, input int c);
		case (c)
			1: return 0;
			2: return 1;
			3: return 2;
			4: return 3;
			5: return 4;
			6: return (p == 2) ? 5 : 4;
			7: return (p == 2) ? 6 : 7;
			default: return 8;
		endcase
	endfunction

	// ********************************
	// Scenarios
	// ********************************
	task t_reset;
		logic [31:0] rd;
		logic        e;
		logic        es;
		for (int p = 0; p < 3; p++)
		begin
			apb(1'b0, `AMS_ADDR_PORT0 + 32'(p * 4), 32'h0, rd, e, es);
			check("reset sel", rd, 32'h0);
			check("reset err", {31'h0, e}, 32'h0);
		end
		// Pins are all high, so any routing but zero would show
		check("reset mute", {29'h0, mute}, 32'h0);
	endtask

	task t_route;
		logic [31:0] rd;
		logic        e;
		logic        es;
		logic [7:0]  hot;
		int          idx;
		for (int p = 0; p < 3; p++)
			for (int c = 0; c < 8; c++)
			begin
				apb(1'b1, `AMS_ADDR_PORT0 + 32'(p * 4), 32'(c), rd, e, es);
				check("write err", {31'h0, e}, 32'h0);
				apb(1'b0, `AMS_ADDR_PORT0 + 32'(p * 4), 32'h0, rd, e, es);
				check("readback", rd, 32'(c));
				idx = exp_idx(p, c);
				hot = (idx < 8) ? (8'h01 << idx) : 8'h00;
				for (int lvl = 0; lvl < 2; lvl++)
				begin
					@(posedge clk);
					pins <= lvl ? hot : ~hot;
					// Two synchroniser flops plus the mux flop
					repeat (4) @(posedge clk);
					#1;
					check("mute", {31'h0, mute[p]}, 32'(lvl && idx < 8));
					check("small mute2", {31'h0, smallMute2}, 32'h0);
				end
			end
	endtask

	task t_reserved;
		logic [31:0] rd;
		logic [31:0] bad [3];
		logic        e;
		logic        es;
		bad = '{32'h4000_0014, 32'h4000_0024, 32'h4000_0019};
		apb(1'b1, `AMS_ADDR_PORT1, 32'h0000_0001, rd, e, es);
		apb(1'b0, `AMS_ADDR_PORT1, 32'h0, rd, e, es);
		check("reserved bits", rd, 32'h1);
		apb(1'b1, `AMS_ADDR_PORT0, 32'h5, rd, e, es);
		foreach (bad[i])
		begin
			apb(1'b1, bad[i], 32'h2, rd, e, es);
			check("unmapped wr err", {31'h0, e}, 32'h1);
			apb(1'b0, bad[i], 32'h0, rd, e, es);
			check("unmapped rd err", {31'h0, e}, 32'h1);
		end
		apb(1'b0, `AMS_ADDR_PORT0, 32'h0, rd, e, es);
		check("sel kept", rd, 32'h5);
		apb(1'b1, `AMS_ADDR_PORT2, 32'h4, rd, e, es);
		check("port2 err", {31'h0, e}, 32'h0);
		check("small port2 err", {31'h0, es}, 32'h1);
	endtask

	// Mid-run reset must clear selectors that software had set
	task t_rereset;
		logic [31:0] rd;
		logic        e;
		logic        es;
		apb(1'b1, `AMS_ADDR_PORT0, 32'h3, rd, e, es);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, `AMS_ADDR_PORT0, 32'h0, rd, e, es);
		check("rereset sel0", rd, 32'h0);
		apb(1'b0, `AMS_ADDR_PORT1, 32'h0, rd, e, es);
		check("rereset sel1", rd, 32'h0);
		check("rereset mute", {29'h0, mute}, 32'h0);
	endtask

	// ********************************
	// Run control
	// ********************************
	task end_sim;
		$display("Checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		$display("Watchdog expired");
		end_sim;
	end

	initial
	begin
		rst_n      = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 32'h0;
		pwdata     = 32'h0;
		pins       = 8'hFF;
		n_mismatch = 0;
		checked    = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_route;
		t_reserved;
		t_rereset;
		end_sim;
	end
endmodule
